// file: rtl/ifd_regs.svh
// Contract
// - bit 9 selects working_register or file destination
// - bit a forces access bank or uses bank_select_register
// - move_file_to_file carries 12-bit source, prefixed destination
// - bit ops extract 3-bit position, a, address
// - literal ops take 8-bit immediate, bits 7..0
// - call/goto join 20-bit target, second word prefixed
// - call first word holds fast bit S
// - decimal_adjust_w adjusts nibbles by 6, sets carry
// - decrement_file subtracts one, updates five flags
// - extended set, a zero, f<=95 uses indexed offset
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH
// register byte offsets
`define IFD_OFF_CTRL   8'h00
`define IFD_OFF_WORD0  8'h04
`define IFD_OFF_WORD1  8'h08
`define IFD_OFF_WORKING_REGISTER   8'h0C
`define IFD_OFF_BSR    8'h10
`define IFD_OFF_FLAGS  8'h14
`define IFD_OFF_FILE   8'h18
`define IFD_OFF_INDEX  8'h1C
`define IFD_OFF_DECA   8'h20
`define IFD_OFF_DECB   8'h24
`define IFD_OFF_DECC   8'h28
// control bit positions
`define IFD_CTRL_GO    0
`define IFD_CTRL_EXT   1
`define IFD_CTRL_BAD   2
`define IFD_CTRL_BUSY  3
// instruction field positions
`define IFD_D_POS      9
`define IFD_A_POS      8
// encodings and limits
`define IFD_ENC_DAW    16'h0007
`define IFD_OPC_DECREMENT_FILE   6'h01
`define IFD_PREFIX     4'hF
`define IFD_IDX_MAX    8'h5F
`define IFD_ACC_HIGH   4'hF
// reset values
`define IFD_RST_WORD   16'h0000
`define IFD_RST_BYTE   8'h00
// bus answers
`define IFD_RESP_OKAY  2'h0
`define IFD_RESP_DEC   2'h3
`endif

// file: rtl/ifd_pkg.sv
package ifd_pkg;
   // execution sequencer, one-hot
   typedef enum logic [1:0] {IFD_IDLE = 2'b01, IFD_EXEC = 2'b10} ifd_state_t;
   // operations the block executes
   typedef enum logic [1:0] {
      IFD_OP_NONE = 2'b00,
      IFD_OP_DAW  = 2'b01,
      IFD_OP_DECREMENT_FILE = 2'b10
   } ifd_op_t;
   // status flags, carry in bit 0
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } ifd_flags_t;
   // every field view of the instruction words
   typedef struct packed {
      logic        dBit;
      logic        aBit;
      logic [2:0]  bitPos;
      logic [7:0]  fileLow;
      logic [11:0] fileAddr;
      logic        indexed;
      logic [11:0] srcAddr;
      logic [11:0] dstAddr;
      logic [7:0]  literal;
      logic [19:0] target;
      logic        fastBit;
      logic        prefixOk;
   } ifd_dec_t;
endpackage

// file: rtl/ifd_decode.sv
`timescale 1ns/1ps
`include "ifd_regs.svh"
module ifd_decode (
   input  wire logic [15:0]      word0,   // first instruction word
   input  wire logic [15:0]      word1,   // second instruction word
   input  wire logic [3:0]       bank_select_register,     // bank_select_register
   input  wire logic             extEn,   // extended set enabled
   input  wire logic [11:0]      idxBase, // indexed offset base
   output ifd_pkg::ifd_dec_t     dec      // decoded fields
);
   import ifd_pkg::*;
   // second words of two-word forms begin with the prefix
   function automatic logic hasPrefix(input logic [15:0] w);
      return w[15:12] == `IFD_PREFIX;
   endfunction
   // pure field extraction, every format view at once
   always_comb begin
      dec          = '0;
      dec.dBit     = word0[`IFD_D_POS];
      dec.aBit     = word0[`IFD_A_POS];
      dec.bitPos   = word0[11:9];
      dec.fileLow  = word0[7:0];
      dec.indexed  = extEn && !word0[`IFD_A_POS] && (word0[7:0] <= `IFD_IDX_MAX);
      if (word0[`IFD_A_POS]) begin
         dec.fileAddr = {bank_select_register, word0[7:0]};
      end else if (dec.indexed) begin
         dec.fileAddr = 12'(idxBase + {4'h0, word0[7:0]});
      end else if (word0[7:0] <= `IFD_IDX_MAX) begin
         dec.fileAddr = {4'h0, word0[7:0]};
      end else begin
         dec.fileAddr = {`IFD_ACC_HIGH, word0[7:0]};
      end
      dec.srcAddr  = word0[11:0];
      dec.dstAddr  = word1[11:0];
      dec.literal  = word0[7:0];
      dec.target   = {word1[11:0], word0[7:0]};
      dec.fastBit  = word0[8];
      dec.prefixOk = hasPrefix(word1);
   end
endmodule

// file: rtl/ifd_alu.sv
`timescale 1ns/1ps
`include "ifd_regs.svh"
module ifd_alu (
   input  wire ifd_pkg::ifd_op_t    op,       // operation
   input  wire logic [7:0]          working_register,     // working_register
   input  wire logic [7:0]          fileVal,  // file operand
   input  wire ifd_pkg::ifd_flags_t flagsIn,  // flags before
   output logic [7:0]               result,   // operation result
   output ifd_pkg::ifd_flags_t      flagsOut  // flags after
);
   import ifd_pkg::*;
   // nibble outside decimal range
   function automatic logic over9(input logic [3:0] v);
      return v > 4'h9;
   endfunction
   logic       lowAdj;  // low nibble needs six
   logic       highAdj; // high nibble needs six
   logic [8:0] step;    // after low adjust
   logic [8:0] dawRes;  // after both adjusts
   // low carry ripples into the high check
   always_comb begin
      lowAdj  = over9(working_register[3:0]) || flagsIn.dc;
      step    = {1'b0, working_register} + (lowAdj ? 9'h006 : 9'h000);
      highAdj = over9(step[7:4]) || flagsIn.c || step[8];
      dawRes  = step + (highAdj ? 9'h060 : 9'h000);
   end
   // result and flag select
   always_comb begin
      flagsOut = flagsIn;
      result   = working_register;
      case (op)
         IFD_OP_DAW: begin
            result     = dawRes[7:0];
            flagsOut.c = highAdj;
         end
         IFD_OP_DECREMENT_FILE: begin
            result      = fileVal - 8'h01;
            flagsOut.c  = fileVal != 8'h00;
            flagsOut.dc = fileVal[3:0] != 4'h0;
            flagsOut.z  = fileVal == 8'h01;
            flagsOut.n  = result[7];
            flagsOut.ov = fileVal == 8'h80;
         end
         default: result = working_register;
      endcase
   end
endmodule

// file: rtl/ifd_top.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ifd_regs.svh"
module ifd_top #(
   parameter int ADDR_W = 8 // bus address width
) (
   input  wire logic              clk,           // 200 MHz core clock
   input  wire logic              reset_n,       // async reset, low
   input  wire logic              s_axi_awvalid, // write address valid
   output logic                   s_axi_awready, // write address ready
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // byte strobes
   output logic                   s_axi_bvalid,  // write response valid
   input  wire logic              s_axi_bready,  // write response ready
   output logic [1:0]             s_axi_bresp,   // write response
   input  wire logic              s_axi_arvalid, // read address valid
   output logic                   s_axi_arready, // read address ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready,  // read data ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output ifd_pkg::ifd_flags_t    flagsOut       // current status flags
);
   import ifd_pkg::*;

   ifd_state_t           state_r;   // sequencer
   logic                 awHeld_r;  // address captured
   logic [ADDR_W-1:0]    awAddr_r;  // captured address
   logic                 wHeld_r;   // data captured
   logic [31:0]          wData_r;   // captured data
   logic [3:0]           wStrb_r;   // captured strobes
   logic                 bvalid_r;  // response pending
   logic [1:0]           bresp_r;   // response code
   logic                 rvalid_r;  // read data pending
   logic [31:0]          rdata_r;   // read data
   logic [1:0]           rresp_r;   // read response
   logic                 extEn_r;   // extended set enable
   logic                 badOp_r;   // sticky unsupported op
   logic [15:0]          word0_r;   // first word
   logic [15:0]          word1_r;   // second word
   logic [7:0]           working_register_r;    // working_register
   logic [3:0]           bsr_r;     // bank_select_register
   ifd_flags_t           flags_r;   // status flags
   logic [7:0]           fileData_r; // addressed file value
   logic [11:0]          idxBase_r; // indexed base
   ifd_dec_t             dec;       // decoded fields
   ifd_op_t              op;        // operation of word0
   logic [7:0]           aluRes;    // alu result
   ifd_flags_t           aluFlags;  // alu flags
   logic                 doWrite;   // commit a bus write
   logic                 execNow;   // commit an operation
   logic                 go;        // launch strobe
   logic [ADDR_W-1:0]    wOff;      // captured write offset, low bits kept

   // byte lanes merge into the old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // word aligned offset compare
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(off);
   endfunction

   // mapped address check
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return ({a[ADDR_W-1:2], 2'b00} <= ADDR_W'(`IFD_OFF_DECC));
   endfunction

   ifd_decode u_decode (
      .word0   (word0_r),
      .word1   (word1_r),
      .bank_select_register     (bsr_r),
      .extEn   (extEn_r),
      .idxBase (idxBase_r),
      .dec     (dec)
   );

   ifd_alu u_alu (
      .op       (op),
      .working_register     (working_register_r),
      .fileVal  (fileData_r),
      .flagsIn  (flags_r),
      .result   (aluRes),
      .flagsOut (aluFlags)
   );

   // operation recognised from the first word
   always_comb begin
      if (word0_r == `IFD_ENC_DAW) begin
         op = IFD_OP_DAW;
      end else if (word0_r[15:10] == `IFD_OPC_DECREMENT_FILE) begin
         op = IFD_OP_DECREMENT_FILE;
      end else begin
         op = IFD_OP_NONE;
      end
   end

   // handshakes; writes refused while an operation commits
   assign s_axi_awready = !awHeld_r && !bvalid_r && (state_r == IFD_IDLE);
   assign s_axi_wready  = !wHeld_r && !bvalid_r && (state_r == IFD_IDLE);
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign flagsOut      = flags_r;
   assign doWrite       = awHeld_r && wHeld_r;
   assign wOff          = awAddr_r;
   assign go            = doWrite && hit(wOff, `IFD_OFF_CTRL) && wStrb_r[0]
                          && wData_r[`IFD_CTRL_GO];
   assign execNow       = state_r == IFD_EXEC;

   // write address capture, either order with data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_r <= 1'b0;
         awAddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_r <= 1'b0;
      end
   end

   // write data capture
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wHeld_r <= 1'b0;
         wData_r <= '0;
         wStrb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_r <= 1'b1;
         wData_r <= s_axi_wdata;
         wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld_r <= 1'b0;
      end
   end

   // write response, held until taken
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `IFD_RESP_OKAY;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         bresp_r  <= mapped(wOff) ? `IFD_RESP_OKAY : `IFD_RESP_DEC;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // sequencer: one commit cycle per launch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= IFD_IDLE;
      end else begin
         case (state_r)
            IFD_IDLE: if (go) begin
               state_r <= IFD_EXEC;
            end
            IFD_EXEC: state_r <= IFD_IDLE;
            default:  state_r <= IFD_IDLE;
         endcase
      end
   end

   // control bits; unsupported-op set wins over clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         extEn_r <= 1'b0;
         badOp_r <= 1'b0;
      end else begin
         if (doWrite && hit(wOff, `IFD_OFF_CTRL) && wStrb_r[0]) begin
            extEn_r <= wData_r[`IFD_CTRL_EXT];
         end
         if (execNow && op == IFD_OP_NONE) begin
            badOp_r <= 1'b1;
         end else if (doWrite && hit(wOff, `IFD_OFF_CTRL) && wStrb_r[0]
                      && wData_r[`IFD_CTRL_BAD]) begin
            badOp_r <= 1'b0;
         end
      end
   end

   // instruction words, bank and index base
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         word0_r   <= `IFD_RST_WORD;
         word1_r   <= `IFD_RST_WORD;
         bsr_r     <= 4'h0;
         idxBase_r <= 12'h000;
      end else if (doWrite) begin
         if (hit(wOff, `IFD_OFF_WORD0)) begin
            word0_r <= 16'(merge({16'h0000, word0_r}, wData_r, wStrb_r));
         end
         if (hit(wOff, `IFD_OFF_WORD1)) begin
            word1_r <= 16'(merge({16'h0000, word1_r}, wData_r, wStrb_r));
         end
         if (hit(wOff, `IFD_OFF_BSR) && wStrb_r[0]) begin
            bsr_r <= wData_r[3:0];
         end
         if (hit(wOff, `IFD_OFF_INDEX)) begin
            idxBase_r <= 12'(merge({20'h00000, idxBase_r}, wData_r, wStrb_r));
         end
      end
   end

   // working_register: software or committed result
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         working_register_r <= `IFD_RST_BYTE;
      end else if (execNow && op == IFD_OP_DAW) begin
         working_register_r <= aluRes;
      end else if (execNow && op == IFD_OP_DECREMENT_FILE && !dec.dBit) begin
         working_register_r <= aluRes;
      end else if (doWrite && hit(wOff, `IFD_OFF_WORKING_REGISTER) && wStrb_r[0]) begin
         working_register_r <= wData_r[7:0];
      end
   end

   // file operand: written back only when d selects it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fileData_r <= `IFD_RST_BYTE;
      end else if (execNow && op == IFD_OP_DECREMENT_FILE && dec.dBit) begin
         fileData_r <= aluRes;
      end else if (doWrite && hit(wOff, `IFD_OFF_FILE) && wStrb_r[0]) begin
         fileData_r <= wData_r[7:0];
      end
   end

   // status flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_r <= '0;
      end else if (execNow && op != IFD_OP_NONE) begin
         flags_r <= aluFlags;
      end else if (doWrite && hit(wOff, `IFD_OFF_FLAGS) && wStrb_r[0]) begin
         flags_r <= wData_r[4:0];
      end
   end

   // read mux, sampled when the address is taken
   function automatic logic [31:0] readWord(input logic [ADDR_W-1:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (hit(a, `IFD_OFF_CTRL)) begin
         v[`IFD_CTRL_EXT]  = extEn_r;
         v[`IFD_CTRL_BAD]  = badOp_r;
         v[`IFD_CTRL_BUSY] = state_r == IFD_EXEC;
      end
      if (hit(a, `IFD_OFF_WORD0)) v[15:0] = word0_r;
      if (hit(a, `IFD_OFF_WORD1)) v[15:0] = word1_r;
      if (hit(a, `IFD_OFF_WORKING_REGISTER))  v[7:0]  = working_register_r;
      if (hit(a, `IFD_OFF_BSR))   v[3:0]  = bsr_r;
      if (hit(a, `IFD_OFF_FLAGS)) v[4:0]  = flags_r;
      if (hit(a, `IFD_OFF_FILE))  v[7:0]  = fileData_r;
      if (hit(a, `IFD_OFF_INDEX)) v[11:0] = idxBase_r;
      if (hit(a, `IFD_OFF_DECA)) begin
         v = {13'h0000, dec.indexed, dec.dBit, dec.aBit, 1'b0, dec.bitPos, dec.fileAddr};
      end
      if (hit(a, `IFD_OFF_DECB)) v = {4'h0, dec.dstAddr, 4'h0, dec.srcAddr};
      if (hit(a, `IFD_OFF_DECC)) begin
         v = {2'h0, dec.prefixOk, dec.fastBit, dec.literal, dec.target};
      end
      return v;
   endfunction

   // read channel, one outstanding
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `IFD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= readWord(s_axi_araddr);
         rresp_r  <= mapped(s_axi_araddr) ? `IFD_RESP_OKAY : `IFD_RESP_DEC;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // checks on the design's own behaviour
   property p_daw_carry;
      @(posedge clk) disable iff (!reset_n)
      (execNow && op == IFD_OP_DAW && working_register_r[7:4] > 4'h9) |=> flags_r.c;
   endproperty
   a_daw_carry: assert property (p_daw_carry) else $error("daw carry missing");

   property p_daw_value;
      @(posedge clk) disable iff (!reset_n)
      (execNow && op == IFD_OP_DAW && working_register_r == 8'hCE && !flags_r.c && !flags_r.dc)
      |=> working_register_r == 8'h34;
   endproperty
   a_daw_value: assert property (p_daw_value) else $error("daw result wrong");

   property p_decrement_file_w;
      @(posedge clk) disable iff (!reset_n)
      (execNow && op == IFD_OP_DECREMENT_FILE && !dec.dBit)
      |=> working_register_r == 8'($past(fileData_r) - 8'h01) && $stable(fileData_r);
   endproperty
   a_decrement_file_w: assert property (p_decrement_file_w) else $error("decrement_file to w wrong");

   property p_decrement_file_f;
      @(posedge clk) disable iff (!reset_n)
      (execNow && op == IFD_OP_DECREMENT_FILE && dec.dBit)
      |=> fileData_r == 8'($past(fileData_r) - 8'h01) && $stable(working_register_r);
   endproperty
   a_decrement_file_f: assert property (p_decrement_file_f) else $error("decrement_file to f wrong");

   property p_decrement_file_zero;
      @(posedge clk) disable iff (!reset_n)
      (execNow && op == IFD_OP_DECREMENT_FILE && fileData_r == 8'h01)
      |=> flags_r.z && flags_r.c && !flags_r.n;
   endproperty
   a_decrement_file_zero: assert property (p_decrement_file_zero) else $error("decrement_file flags wrong");

   property p_bank;
      @(posedge clk) disable iff (!reset_n)
      dec.aBit |-> dec.fileAddr == {bsr_r, word0_r[7:0]};
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");

   property p_access;
      @(posedge clk) disable iff (!reset_n)
      (!dec.aBit && !extEn_r) |-> dec.fileAddr[11:8] inside {4'h0, 4'hF};
   endproperty
   a_access: assert property (p_access) else $error("access bank wrong");

   property p_indexed;
      @(posedge clk) disable iff (!reset_n)
      (extEn_r && !dec.aBit && word0_r[7:0] <= 8'h5F)
      |-> dec.indexed && dec.fileAddr == 12'(idxBase_r + {4'h0, word0_r[7:0]});
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");

   property p_target;
      @(posedge clk) disable iff (!reset_n)
      dec.target == {word1_r[11:0], word0_r[7:0]} && dec.fastBit == word0_r[8]
      && dec.prefixOk == (word1_r[15:12] == 4'hF);
   endproperty
   a_target: assert property (p_target) else $error("target decode wrong");

   property p_fields;
      @(posedge clk) disable iff (!reset_n)
      dec.bitPos == word0_r[11:9] && dec.literal == word0_r[7:0]
      && dec.srcAddr == word0_r[11:0] && dec.dBit == word0_r[9];
   endproperty
   a_fields: assert property (p_fields) else $error("field decode wrong");

   property p_bhold;
      @(posedge clk) disable iff (!reset_n)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

   property p_launch;
      @(posedge clk) disable iff (!reset_n)
      go |=> execNow ##1 !execNow;
   endproperty
   a_launch: assert property (p_launch) else $error("launch not one cycle");

   c_daw: cover property (@(posedge clk) disable iff (!reset_n) execNow && op == IFD_OP_DAW);
   c_decrement_file: cover property (@(posedge clk) disable iff (!reset_n)
      execNow && op == IFD_OP_DECREMENT_FILE && !dec.dBit);
   c_write: cover property (@(posedge clk) disable iff (!reset_n) doWrite);
   c_read: cover property (@(posedge clk) disable iff (!reset_n)
      s_axi_rvalid && s_axi_rready);
endmodule

// file: sim/ifd_top_tb.sv
`timescale 1ns/1ps
`include "ifd_regs.svh"
module ifd_top_tb;
   import ifd_pkg::*;
   logic              clk;        // 200 MHz
   logic              reset_n;    // async, low
   logic              awvalid;    // write address valid
   logic              awready;    // write address ready
   logic [7:0]        awaddr;     // write address
   logic              wvalid;     // write data valid
   logic              wready;     // write data ready
   logic [31:0]       wdata;      // write data
   logic              bvalid;     // response valid
   logic [1:0]        bresp;      // write response
   logic              arvalid;    // read address valid
   logic              arready;    // read address ready
   logic [7:0]        araddr;     // read address
   logic              rvalid;     // read data valid
   logic [31:0]       rdata;      // read data
   logic [1:0]        rresp;      // read response
   ifd_flags_t        flags;      // live flags
   int                n_mismatch; // mismatches seen
   int                compares;   // comparisons made

   // responses always accepted, full-word writes only
   ifd_top u_ifd_top (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .flagsOut(flags));

   // free-running core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // verdict and end of run
   task automatic stop_test();
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one comparison, reported on mismatch
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // ready sampled at negedge: stable until the taking edge, so no race
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      int i;
      logic ah, wh, bh;
      logic [1:0] r;
      bh = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 50 && !bh; i++) begin
         @(negedge clk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = (bvalid === 1'b1);
         r = bresp;
         @(posedge clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end
      if (!bh) begin
         n_mismatch++;
         stop_test();
      end else begin
         check({30'h0, r}, {30'h0, er});
      end
   endtask

   // read with data and response compared
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      int i;
      logic ah, rh;
      logic [31:0] d;
      logic [1:0] r;
      rh = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 50 && !rh; i++) begin
         @(negedge clk);
         ah = arvalid & arready;
         rh = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ah) arvalid <= 1'b0;
      end
      if (!rh) begin
         n_mismatch++;
         stop_test();
      end else begin
         check(d, e);
         check({30'h0, r}, {30'h0, er});
      end
   endtask

   // load word0 and pulse go; one execute cycle follows
   task automatic exec(input logic [15:0] w0, input logic ext);
      wr(`IFD_OFF_WORD0, {16'h0, w0});
      wr(`IFD_OFF_CTRL, {30'h0, ext, 1'b1});
      repeat (2) @(posedge clk);
   endtask

   // decrement with a known operand, working_register preset to 55
   task automatic decrement_file(input logic [15:0] w0, input logic [7:0] fv, input logic [7:0] ew,
                       input logic [7:0] ef, input logic [4:0] efl);
      wr(`IFD_OFF_WORKING_REGISTER, 32'h55);
      wr(`IFD_OFF_FILE, {24'h0, fv});
      wr(`IFD_OFF_FLAGS, 32'h0);
      exec(w0, 1'b0);
      rd(`IFD_OFF_WORKING_REGISTER, {24'h0, ew});
      rd(`IFD_OFF_FILE, {24'h0, ef});
      rd(`IFD_OFF_FLAGS, {27'h0, efl});
      check({27'h0, flags}, {27'h0, efl});
   endtask

   // decode view of a word pair
   task automatic dv(input logic [15:0] w0, input logic [15:0] w1, input logic [7:0] o,
                     input logic [31:0] e);
      wr(`IFD_OFF_WORD0, {16'h0, w0});
      wr(`IFD_OFF_WORD1, {16'h0, w1});
      rd(o, e);
   endtask

   // adjust: preset working_register and flags, check result and carry
   task automatic decimal_adjust_w(input logic [7:0] w, input logic [4:0] f, input logic [7:0] ew,
                      input logic [4:0] ef);
      wr(`IFD_OFF_WORKING_REGISTER, {24'h0, w});
      wr(`IFD_OFF_FLAGS, {27'h0, f});
      exec(`IFD_ENC_DAW, 1'b0);
      rd(`IFD_OFF_WORKING_REGISTER, {24'h0, ew});
      rd(`IFD_OFF_FLAGS, {27'h0, ef});
   endtask

   // main sequence
   initial begin
      n_mismatch = 0;
      compares = 0;
      reset_n = 1'b0;
      {awvalid, wvalid, arvalid} = 3'h0;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(`IFD_OFF_CTRL, 32'h0);
      rd(`IFD_OFF_FLAGS, 32'h0);
      check({27'h0, flags}, 32'h0);
      wr(8'h2C, 32'hFF, `IFD_RESP_DEC);
      rd(8'h2C, 32'h0, `IFD_RESP_DEC);
      decimal_adjust_w(8'hA5, 5'h00, 8'h05, 5'h01);
      decimal_adjust_w(8'hCE, 5'h00, 8'h34, 5'h01);
      decimal_adjust_w(8'h12, 5'h02, 8'h18, 5'h02);
      decrement_file(16'h0610, 8'h01, 8'h55, 8'h00, 5'h07);
      decrement_file(16'h0410, 8'h80, 8'h7F, 8'h80, 5'h09);
      decrement_file(16'h0700, 8'h00, 8'h55, 8'hFF, 5'h10);
      wr(`IFD_OFF_BSR, 32'h3);
      wr(`IFD_OFF_INDEX, 32'h100);
      dv(16'h0B22, 16'h0, `IFD_OFF_DECA, 32'h35322);
      dv(16'h045F, 16'h0, `IFD_OFF_DECA, 32'h0205F);
      dv(16'h0460, 16'h0, `IFD_OFF_DECA, 32'h02F60);
      dv(16'hCABC, 16'hF123, `IFD_OFF_DECB, 32'h01230ABC);
      dv(16'hED5A, 16'hF987, `IFD_OFF_DECC, 32'h35A9875A);
      dv(16'hED5A, 16'hE987, `IFD_OFF_DECC, 32'h15A9875A);
      dv(16'h0E7F, 16'h0, `IFD_OFF_DECC, 32'h07F0007F);
      wr(`IFD_OFF_CTRL, 32'h2);
      rd(`IFD_OFF_CTRL, 32'h2);
      dv(16'h045F, 16'h0, `IFD_OFF_DECA, 32'h4215F);
      dv(16'h0460, 16'h0, `IFD_OFF_DECA, 32'h02F60);
      exec(16'h1234, 1'b1);
      rd(`IFD_OFF_CTRL, 32'h6);
      wr(`IFD_OFF_CTRL, 32'h4);
      rd(`IFD_OFF_CTRL, 32'h0);
      stop_test();
   end
endmodule
